// *** hw/sdram_cmd_core.sv ***
// command, mode register and burst handling of the sdram device
`timescale 1ns/1ps
module sdram_cmd_core
  import sdram_cmd_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              cke,
  input  wire logic              cs_n,
  input  wire logic              ras_n,
  input  wire logic              cas_n,
  input  wire logic              we_n,
  input  wire logic              bank_select_low,
  input  wire logic              bank_select_high,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [LANES-1:0]  dqm,
  input  wire logic [DQ_W-1:0]   dq_in,
  output logic      [DQ_W-1:0]   dq_out,
  output logic      [LANES-1:0]  dq_oe,
  output logic                   core_act,
  output logic      [BANK_W-1:0] core_act_bank,
  output logic      [ADDR_W-1:0] core_act_row,
  output logic                   core_rd,
  output logic                   core_wr,
  output logic      [BANK_W-1:0] core_bank,
  output logic      [COL_W-1:0]  core_col,
  output logic                   core_auto_pre,
  output logic      [DQ_W-1:0]   core_wr_data,
  output logic      [LANES-1:0]  core_wr_be,
  input  wire logic [DQ_W-1:0]   core_rd_data,
  output logic                   core_pre,
  output logic      [BANKS-1:0]  core_pre_banks,
  output logic                   core_ref,
  output logic      [ADDR_W-1:0] core_ref_row,
  output logic                   self_refresh,
  output logic                   mode_normal
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ****************************
  // command decode
  // ****************************
  cmd_t              cmd_pin;
  cmd_t              cmd;
  logic [BANK_W-1:0] bank;
  logic [ADDR_W-1:0] mode_r;
  logic              mode_loaded_r;
  logic [1:0]        lat;
  logic [COL_W-1:0]  bmask;
  logic [LANES-1:0]  wr_be;

  // RQ22 pins are used at the edge they are sampled
  sdram_cmd_decode sdram_cmd_decode_inst (
    .cke   (cke),
    .cs_n  (cs_n),
    .ras_n (ras_n),
    .cas_n (cas_n),
    .we_n  (we_n),
    .cmd   (cmd_pin)
  );

  // RQ12 self refresh ignores every pin but clock enable
  assign cmd  = self_refresh ? CMD_INHIBIT : cmd_pin;
  assign bank = {bank_select_high, bank_select_low};

  // ****************************
  // mode register
  // ****************************
  // RQ21 no reset: contents stay unknown until the first load
  // RQ13 op-code from the address pins
  always_ff @(posedge clk)
    if (cmd == CMD_MODE_REGISTER_LOAD)
      mode_r <= addr;

  always_ff @(posedge clk)
    if (!rst_n)
      mode_loaded_r <= 1'b0;
    else if (cmd == CMD_MODE_REGISTER_LOAD)
      mode_loaded_r <= 1'b1;

  // RQ20 field extraction
  assign bmask = burst_mask(mode_r[MR_BURST_LEN_LSB +: 3]);
  // RQ2 latency one to three
  assign lat   = read_lat(mode_r[MR_LAT_LSB +: 3]);
  assign mode_normal = mode_loaded_r &&
                       (mode_r[MR_OPMODE_LSB +: 2] == OPMODE_NORMAL);

  // ****************************
  // burst sequencing
  // ****************************
  logic [COL_W-1:0]  left_r;
  logic [COL_W-1:0]  idx_r;
  logic [COL_W-1:0]  start_r;
  logic [BANK_W-1:0] acc_bank_r;
  logic              acc_wr_r;
  logic              acc_ap_r;
  logic              new_acc;
  logic              beat;
  logic              beat_wr;
  logic [COL_W-1:0]  beat_k;
  logic [COL_W-1:0]  beat_start;
  logic [COL_W-1:0]  beat_off;
  logic [COL_W-1:0]  beat_col;

  assign new_acc = (cmd == CMD_READ) || (cmd == CMD_WRITE);
  // RQ8 idle commands let a running burst go on
  assign beat    = new_acc ||
                   ((left_r != '0) && (cmd != CMD_BURST_STOP));
  assign beat_wr    = new_acc ? (cmd == CMD_WRITE) : acc_wr_r;
  assign beat_k     = new_acc ? '0 : idx_r;
  // RQ15 column from the low address pins
  assign beat_start = new_acc ? addr[COL_W-1:0] : start_r;
  // interleaved order is start xor beat, sequential is start plus beat
  assign beat_off   = mode_r[MR_BURST_TYPE] ? (beat_start ^ beat_k) :
                      COL_W'(beat_start + beat_k);
  // wrap inside the block chosen by the burst length
  assign beat_col   = (beat_start & ~bmask) | (beat_off & bmask);

  always_ff @(posedge clk)
    if (!rst_n)
    begin
      left_r   <= '0;
      idx_r    <= '0;
      acc_wr_r <= 1'b0;
    end
    else if (new_acc)
    begin
      // RQ5 write single mode cuts writes to one beat
      if (cmd == CMD_WRITE && mode_r[MR_WR_SINGLE])
        left_r <= '0;
      else
        left_r <= bmask;
      idx_r    <= COL_W'(1);
      acc_wr_r <= (cmd == CMD_WRITE);
    end
    else if (cmd == CMD_BURST_STOP)
      left_r <= '0;
    else if (left_r != '0)
    begin
      left_r <= COL_W'(left_r - COL_W'(1));
      idx_r  <= COL_W'(idx_r + COL_W'(1));
    end

  // RQ15 bank and auto precharge captured per access
  always_ff @(posedge clk)
    if (new_acc)
    begin
      start_r    <= addr[COL_W-1:0];
      acc_bank_r <= bank;
      acc_ap_r   <= addr[AUTO_PRE_BIT];
    end

  // ****************************
  // array side requests
  // ****************************
  always_ff @(posedge clk)
    if (!rst_n)
    begin
      core_rd       <= 1'b0;
      core_wr       <= 1'b0;
      core_bank     <= '0;
      core_col      <= '0;
      core_auto_pre <= 1'b0;
      core_wr_data  <= '0;
      core_wr_be    <= '0;
    end
    else
    begin
      core_rd <= beat && !beat_wr;
      core_wr <= beat && beat_wr;
      if (beat)
      begin
        core_bank     <= new_acc ? bank : acc_bank_r;
        core_col      <= beat_col;
        core_auto_pre <= new_acc ? addr[AUTO_PRE_BIT] : acc_ap_r;
        core_wr_data  <= dq_in;
        // RQ17 write mask coincident with data
        core_wr_be    <= wr_be;
      end
    end

  // RQ14 row and bank for activate
  always_ff @(posedge clk)
    if (!rst_n)
    begin
      core_act      <= 1'b0;
      core_act_bank <= '0;
      core_act_row  <= '0;
    end
    else
    begin
      core_act <= (cmd == CMD_ACTIVATE);
      if (cmd == CMD_ACTIVATE)
      begin
        core_act_bank <= bank;
        core_act_row  <= addr;
      end
    end

  // RQ16 one bank by select, or all banks
  always_ff @(posedge clk)
    if (!rst_n)
    begin
      core_pre       <= 1'b0;
      core_pre_banks <= '0;
    end
    else
    begin
      core_pre <= (cmd == CMD_PRECHARGE);
      if (cmd == CMD_PRECHARGE)
        core_pre_banks <= addr[AUTO_PRE_BIT] ? ALL_BANKS :
                          (BANKS'(1) << bank);
    end

  // ****************************
  // refresh
  // ****************************
  logic [ADDR_W-1:0] ref_cnt_r;

  // RQ12 refresh row from the internal counter
  always_ff @(posedge clk)
    if (!rst_n)
    begin
      ref_cnt_r    <= '0;
      core_ref     <= 1'b0;
      core_ref_row <= '0;
    end
    else
    begin
      core_ref <= (cmd == CMD_AUTO_REFRESH) ||
                  (cmd == CMD_SELF_REFRESH);
      if (cmd == CMD_AUTO_REFRESH || cmd == CMD_SELF_REFRESH)
      begin
        core_ref_row <= ref_cnt_r;
        ref_cnt_r    <= ADDR_W'(ref_cnt_r + ADDR_W'(1));
      end
    end

  // RQ11 self refresh held until clock enable returns high
  always_ff @(posedge clk)
    if (!rst_n)
      self_refresh <= 1'b0;
    else if (cmd == CMD_SELF_REFRESH)
      self_refresh <= 1'b1;
    else if (self_refresh && cke)
      self_refresh <= 1'b0;

  // ****************************
  // read output lanes
  // ****************************
  sdram_read_lanes sdram_read_lanes_inst (
    .clk          (clk),
    .rst_n        (rst_n),
    .rd_beat      (beat && !beat_wr),
    .lat          (lat),
    .dqm          (dqm),
    .core_rd_data (core_rd_data),
    .dq_out       (dq_out),
    .dq_oe        (dq_oe),
    .wr_be        (wr_be)
  );

  // ****************************
  // checks
  // ****************************
  a_lat_one: assert property ( // RQ1
    (cmd == CMD_READ && lat == RL_ONE) |-> ##1 dq_oe == ~$past(dqm, 3))
    else $error("latency one drive not at first edge");

  a_lat_two: assert property ( // RQ2
    (cmd == CMD_READ && lat == RL_TWO) |-> ##2 dq_oe == ~$past(dqm, 3))
    else $error("latency two drive misplaced");

  a_lat_three: assert property ( // RQ2
    (cmd == CMD_READ && lat == RL_THREE) |->
      ##3 dq_oe == ~$past(dqm, 3))
    else $error("latency three drive misplaced");

  a_data_two: assert property ( // RQ1
    (cmd == CMD_READ && lat == RL_TWO && left_r == '0) |->
      ##3 dq_out == $past(core_rd_data, 2))
    else $error("read data not valid at latency edge");

  a_deselect_quiet: assert property ( // RQ7
    cs_n |=> !core_act && !core_pre && !core_ref &&
      (!mode_loaded_r || $stable(mode_r)))
    else $error("command taken while deselected");

  a_idle_burst: assert property ( // RQ8
    (cmd == CMD_NO_OPERATION && left_r > COL_W'(1)) |=>
      left_r == $past(left_r) - COL_W'(1))
    else $error("idle command disturbed a burst");

  a_act_decode: assert property ( // RQ9
    (cmd == CMD_ACTIVATE) |=> core_act && core_act_row == $past(addr))
    else $error("activate not decoded");

  a_write_single: assert property ( // RQ5
    (cmd == CMD_WRITE && mode_r[MR_WR_SINGLE]) |=> left_r == '0)
    else $error("single write mode ran a burst");

  a_write_mask: assert property ( // RQ17
    (cmd == CMD_WRITE) |=> core_wr && core_wr_be == ~$past(dqm)
      && core_wr_data == $past(dq_in))
    else $error("write mask or data not taken with command");

  a_pre_all: assert property ( // RQ16
    (cmd == CMD_PRECHARGE && addr[AUTO_PRE_BIT]) |=>
      core_pre && core_pre_banks == ALL_BANKS)
    else $error("precharge all missed a bank");

  a_self_ref: assert property ( // RQ11
    (cmd == CMD_SELF_REFRESH) |=> self_refresh ##1
      (self_refresh == !$past(cke)))
    else $error("self refresh not entered");

  a_mode_load: assert property ( // RQ13
    (cmd == CMD_MODE_REGISTER_LOAD) |=> mode_r == $past(addr))
    else $error("mode register did not take op-code");

  c_read_lat3: cover property (cmd == CMD_READ && lat == RL_THREE);
  c_write_burst: cover property (cmd == CMD_WRITE && left_r == '0
                                 ##1 left_r != '0);
  c_burst_stop: cover property (left_r != '0 && cmd == CMD_BURST_STOP);
  c_self_ref: cover property (self_refresh ##1 !self_refresh);

endmodule // sdram_cmd_core

// *** common/sdram_cmd_pkg.sv ***
// constants, types and decode helpers for the sdram command block
//Behaviour
//RQ1: drive from edge n+m-1, valid by n+m
//RQ2: read latency selectable as one, two, three
//RQ3: controller matches latency to clock frequency
//RQ4: controller writes operating mode bits as zero
//RQ5: write single mode makes writes one location
//RQ6: controller never writes reserved or test codes
//RQ7: chip select high blocks new commands
//RQ8: no operation leaves running bursts alone
//RQ9: strobe pattern decodes to the seven commands; the decoder takes eight patterns
//RQ10: clock enable high except entering self refresh
//RQ11: refresh with clock enable low self refreshes
//RQ12: refresh row comes from internal counter
//RQ13: mode load takes op-code from address
//RQ14: activate takes row and bank
//RQ15: access takes column, bank, auto precharge
//RQ16: precharge closes one bank or all
//RQ17: mask gates writes now, reads two later
//RQ18: one mask input per byte lane
//RQ19: mode load only idle, then wait delay
//RQ20: mode register field layout
//RQ21: mode register unknown until loaded, then kept
//RQ22: all inputs sampled on rising clock edge
package sdram_cmd_pkg;

  localparam int ADDR_W = 12;
  localparam int COL_W  = 8;
  localparam int BANK_W = 2;
  localparam int BANKS  = 4;
  localparam int LANES  = 4;
  localparam int LANE_W = 8;
  localparam int DQ_W   = LANES * LANE_W;

  // ****************************
  // mode register layout
  // ****************************
  localparam int MR_BURST_LEN_LSB = 0;
  localparam int MR_BURST_TYPE    = 3;
  localparam int MR_LAT_LSB       = 4;
  localparam int MR_OPMODE_LSB    = 7;
  localparam int MR_WR_SINGLE     = 9;
  localparam int AUTO_PRE_BIT     = 10;

  localparam logic [1:0] OPMODE_NORMAL = 2'h0;
  localparam logic [2:0] BLEN_2    = 3'h1;
  localparam logic [2:0] BLEN_4    = 3'h2;
  localparam logic [2:0] BLEN_8    = 3'h3;
  localparam logic [2:0] BLEN_PAGE = 3'h7;
  localparam logic [7:0] BMASK_1    = 8'h00;
  localparam logic [7:0] BMASK_2    = 8'h01;
  localparam logic [7:0] BMASK_4    = 8'h03;
  localparam logic [7:0] BMASK_8    = 8'h07;
  localparam logic [7:0] BMASK_PAGE = 8'hff;
  localparam logic [2:0] LAT_CODE_1 = 3'h1;
  localparam logic [2:0] LAT_CODE_2 = 3'h2;
  localparam logic [1:0] RL_ONE     = 2'h1;
  localparam logic [1:0] RL_TWO     = 2'h2;
  localparam logic [1:0] RL_THREE   = 2'h3;
  localparam logic [3:0] ALL_BANKS  = 4'hf;

  // strobe patterns {ras_n, cas_n, we_n} with chip select low
  localparam logic [2:0] ENC_IDLE  = 3'h7;
  localparam logic [2:0] ENC_ACT   = 3'h3;
  localparam logic [2:0] ENC_RD    = 3'h5;
  localparam logic [2:0] ENC_WR    = 3'h4;
  localparam logic [2:0] ENC_BTERM = 3'h6;
  localparam logic [2:0] ENC_PRE   = 3'h2;
  localparam logic [2:0] ENC_REF   = 3'h1;
  localparam logic [2:0] ENC_MODE  = 3'h0;

  typedef enum logic [3:0] {
    CMD_INHIBIT            = 4'h0,
    CMD_NO_OPERATION       = 4'h1,
    CMD_ACTIVATE           = 4'h2,
    CMD_READ               = 4'h3,
    CMD_WRITE              = 4'h4,
    CMD_BURST_STOP         = 4'h5,
    CMD_PRECHARGE          = 4'h6,
    CMD_AUTO_REFRESH       = 4'h7,
    CMD_SELF_REFRESH       = 4'h8,
    CMD_MODE_REGISTER_LOAD = 4'h9
  } cmd_t;

  // reserved burst codes fall back to a single beat
  function automatic logic [COL_W-1:0] burst_mask(input logic [2:0] code);
    case (code)
      BLEN_2:    burst_mask = BMASK_2;
      BLEN_4:    burst_mask = BMASK_4;
      BLEN_8:    burst_mask = BMASK_8;
      BLEN_PAGE: burst_mask = BMASK_PAGE;
      default:   burst_mask = BMASK_1;
    endcase
  endfunction

  // reserved latency codes fall back to the slowest setting
  function automatic logic [1:0] read_lat(input logic [2:0] code);
    case (code)
      LAT_CODE_1: read_lat = RL_ONE;
      LAT_CODE_2: read_lat = RL_TWO;
      default:    read_lat = RL_THREE;
    endcase
  endfunction

endpackage

// *** hw/sdram_cmd_decode.sv ***
// command decoder for the strobe, select and clock enable pins
`timescale 1ns/1ps
module sdram_cmd_decode
  import sdram_cmd_pkg::*;
(
  input  wire logic cke,
  input  wire logic cs_n,
  input  wire logic ras_n,
  input  wire logic cas_n,
  input  wire logic we_n,
  output cmd_t      cmd
);

  always_comb
  begin
    cmd = CMD_INHIBIT;
    // RQ7 deselect
    if (!cs_n)
    begin
      // RQ9 strobe decode
      unique case ({ras_n, cas_n, we_n})
        ENC_IDLE:  cmd = CMD_NO_OPERATION;
        ENC_ACT:   cmd = CMD_ACTIVATE;
        ENC_RD:    cmd = CMD_READ;
        ENC_WR:    cmd = CMD_WRITE;
        ENC_BTERM: cmd = CMD_BURST_STOP;
        ENC_PRE:   cmd = CMD_PRECHARGE;
        // RQ11 refresh kind
        ENC_REF:   cmd = cke ? CMD_AUTO_REFRESH : CMD_SELF_REFRESH;
        ENC_MODE:  cmd = CMD_MODE_REGISTER_LOAD;
      endcase
      // clock suspended: nothing but self refresh entry is taken
      if (!cke && cmd != CMD_SELF_REFRESH)
        cmd = CMD_INHIBIT;
    end
  end

endmodule // sdram_cmd_decode

// *** hw/sdram_read_lanes.sv ***
// read output pipeline with per-lane byte masks
`timescale 1ns/1ps
module sdram_read_lanes
  import sdram_cmd_pkg::*;
#(
  parameter int NLANES = LANES,
  parameter int LW     = LANE_W
)
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 rd_beat,
  input  wire logic [1:0]           lat,
  input  wire logic [NLANES-1:0]    dqm,
  input  wire logic [NLANES*LW-1:0] core_rd_data,
  output logic      [NLANES*LW-1:0] dq_out,
  output logic      [NLANES-1:0]    dq_oe,
  output logic      [NLANES-1:0]    wr_be
);

  logic [1:0]           beat_d_r;
  logic [NLANES-1:0]    dqm_d1_r;
  logic [NLANES-1:0]    dqm_d2_r;
  logic [NLANES*LW-1:0] data_d1_r;
  logic [NLANES*LW-1:0] data_d2_r;
  logic                 beat_sel;

  always_ff @(posedge clk)
    if (!rst_n)
    begin
      beat_d_r <= '0;
      dqm_d1_r <= '1;
      dqm_d2_r <= '1;
    end
    else
    begin
      beat_d_r <= {beat_d_r[0], rd_beat};
      dqm_d1_r <= dqm;
      dqm_d2_r <= dqm_d1_r;
    end

  always_ff @(posedge clk)
  begin
    data_d1_r <= core_rd_data;
    data_d2_r <= data_d1_r;
  end

  // RQ1 drive starts latency minus one after the beat
  assign beat_sel = (lat == RL_ONE) ? rd_beat :
                    (lat == RL_TWO) ? beat_d_r[0] : beat_d_r[1];

  // RQ17 write mask takes effect in the same cycle
  assign wr_be = ~dqm;

  genvar i;
  for (i = 0; i < NLANES; i++)
  begin : g_lane
    // RQ18 one mask bit per byte lane
    always_ff @(posedge clk)
      if (!rst_n)
      begin
        dq_oe[i]             <= 1'b0;
        dq_out[i*LW +: LW]   <= '0;
      end
      else
      begin
        // RQ17 read mask seen two clocks late
        dq_oe[i] <= beat_sel & ~dqm_d2_r[i];
        // data lands one edge after drive begins
        dq_out[i*LW +: LW] <= (lat == RL_ONE) ? core_rd_data[i*LW +: LW] :
                              (lat == RL_TWO) ? data_d1_r[i*LW +: LW] :
                                                data_d2_r[i*LW +: LW];
      end
  end

  // ****************************
  // checks
  // ****************************
  a_read_mask: assert property (@(posedge clk) disable iff (!rst_n)
    beat_sel |=> dq_oe == ~$past(dqm, 3)) // RQ17
    else $error("read lane enable does not follow delayed mask");

endmodule // sdram_read_lanes

// *** tb/sdram_array_model.sv ***
// behavioural storage array answering the core read requests
`timescale 1ns/1ps
module sdram_array_model
  import sdram_cmd_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              core_rd,
  input  wire logic [BANK_W-1:0] core_bank,
  input  wire logic [COL_W-1:0]  core_col,
  output logic      [DQ_W-1:0]   core_rd_data
);
  logic junk_r = 1'b0;

  // idle data toggles so a stale word never passes for a good one
  always_ff @(posedge clk)
    junk_r <= ~junk_r;

  // word depends on bank and column, ready within the pulse cycle
  always_comb
    core_rd_data = core_rd ? {8'ha5, 6'h00, core_bank, core_col, ~core_col}
                           : {DQ_W{junk_r}};
endmodule // sdram_array_model

// *** tb/sdram_cmd_core_tb.sv ***
// self-checking bench for the sdram command and mode block
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin n_tests++; if ((got) !== (exp)) begin fails++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); \
  end end
module sdram_cmd_core_tb;
  import sdram_cmd_pkg::*;
  // mode_set_delay in cycles, plain default
  localparam int MODE_DELAY = 2;
  localparam int LIMIT      = 2000;
  localparam logic [DQ_W-1:0] HI_LANES = 32'hff00ff00;

  logic              clk, rst_n, cke, cs_n, ras_n, cas_n, we_n;
  logic              bank_select_low, bank_select_high;
  logic [ADDR_W-1:0] addr, core_act_row, core_ref_row, row;
  logic [LANES-1:0]  dqm, dq_oe, core_wr_be;
  logic [DQ_W-1:0]   dq_in, dq_out, core_wr_data, core_rd_data;
  logic              core_act, core_rd, core_wr, core_auto_pre;
  logic              core_pre, core_ref, self_refresh, mode_normal;
  logic [BANK_W-1:0] core_act_bank, core_bank;
  logic [COL_W-1:0]  core_col;
  logic [BANKS-1:0]  core_pre_banks;
  int                fails = 0, n_tests = 0, cycles = 0;
  int                n_rd = 0, n_wr = 0;

  sdram_cmd_core sdram_cmd_core_inst (
    .clk(clk), .rst_n(rst_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank_select_low(bank_select_low),
    .bank_select_high(bank_select_high), .addr(addr), .dqm(dqm),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .core_act(core_act),
    .core_act_bank(core_act_bank), .core_act_row(core_act_row),
    .core_rd(core_rd), .core_wr(core_wr), .core_bank(core_bank),
    .core_col(core_col), .core_auto_pre(core_auto_pre),
    .core_wr_data(core_wr_data), .core_wr_be(core_wr_be),
    .core_rd_data(core_rd_data), .core_pre(core_pre),
    .core_pre_banks(core_pre_banks), .core_ref(core_ref),
    .core_ref_row(core_ref_row), .self_refresh(self_refresh),
    .mode_normal(mode_normal)
  );

  sdram_array_model sdram_array_model_inst (
    .clk(clk), .core_rd(core_rd), .core_bank(core_bank),
    .core_col(core_col), .core_rd_data(core_rd_data)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // beat counters read the pre-update value, so no race with the design
  always @(posedge clk)
  begin
    cycles++;
    if (core_rd === 1'b1) n_rd++;
    if (core_wr === 1'b1) n_wr++;
    if (cycles == LIMIT)
    begin
      fails++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (fails == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  function automatic logic [DQ_W-1:0] rdpat(logic [1:0] b, logic [7:0] c);
    return {8'ha5, 6'h00, b, c, ~c};
  endfunction

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // pins change at the falling edge only
  task automatic issue(input logic [2:0] enc, input logic [1:0] ba,
                       input logic [ADDR_W-1:0] a);
    @(negedge clk);
    {cs_n, ras_n, cas_n, we_n} = {1'b0, enc};
    {bank_select_high, bank_select_low} = ba;
    addr = a;
    @(negedge clk);
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    addr = ~a;
    dq_in = ~dq_in;
  endtask

  // only when idle, then wait out the delay
  task automatic load_mode(input logic ws, input logic [1:0] om,
                           input logic [2:0] lat, input logic [2:0] bl);
    issue(ENC_MODE, 2'h0, {2'h0, ws, om, lat, 1'b0, bl});
    idle(MODE_DELAY);
  endtask

  // ****************************
  // scenarios
  // ****************************
  task automatic t_mode();
    `CHK(mode_normal, 1'b0)
    `CHK({core_act, core_rd, core_wr, dq_oe}, 7'h00)
    load_mode(1'b1, 2'h0, 3'h2, 3'h0);
    `CHK(mode_normal, 1'b1)
    load_mode(1'b0, 2'h0, 3'h2, 3'h0);
    `CHK(mode_normal, 1'b1)
    idle(20);
    `CHK(mode_normal, 1'b1)
  endtask

  task automatic t_act();
    issue(ENC_ACT, 2'h3, 12'habc);
    `CHK(core_act, 1'b1)
    `CHK(core_act_bank, 2'h3)
    `CHK(core_act_row, 12'habc)
    @(negedge clk);
    {cs_n, ras_n, cas_n, we_n} = {1'b1, ENC_ACT};
    @(negedge clk);
    `CHK(core_act, 1'b0)
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
  endtask

  task automatic t_latency();
    for (int m = 1; m <= 3; m++)
    begin
      load_mode(1'b0, 2'h0, 3'(m), 3'h0);
      // mask must settle two edges ahead of the drive edge
      dqm = 4'h5;
      idle(2);
      issue(ENC_RD, 2'h1, 12'h400 | 12'(8'h30 + m));
      `CHK(core_rd, 1'b1)
      `CHK(core_col, 8'(8'h30 + m))
      `CHK({core_bank, core_auto_pre}, 3'h3)
      if (m > 1)
      begin
        `CHK(dq_oe, 4'h0)
      end
      idle(m - 1);
      `CHK(dq_oe, 4'ha)
      @(negedge clk);
      `CHK(dq_out & HI_LANES, rdpat(2'h1, 8'(8'h30 + m)) & HI_LANES)
      dqm = 4'h0;
    end
  endtask

  task automatic t_write();
    dq_in = 32'h12345678;
    dqm = 4'h6;
    issue(ENC_WR, 2'h2, 12'h015);
    `CHK(core_wr, 1'b1)
    `CHK(core_wr_be, 4'h9)
    `CHK(core_wr_data & 32'hff0000ff, 32'h12000078)
    `CHK({core_bank, core_col, core_auto_pre}, 11'h42a)
    dqm = 4'h0;
  endtask

  task automatic t_burst();
    load_mode(1'b1, 2'h0, 3'h2, BLEN_4);
    n_rd = 0;
    issue(ENC_RD, 2'h0, 12'h001);
    idle(6);
    `CHK(n_rd, 4)
    n_wr = 0;
    issue(ENC_WR, 2'h0, 12'h001);
    idle(6);
    `CHK(n_wr, 1)
    load_mode(1'b0, 2'h0, 3'h2, BLEN_4);
    n_wr = 0;
    @(negedge clk);
    {cs_n, ras_n, cas_n, we_n} = {1'b0, ENC_WR};
    addr = 12'h002;
    @(negedge clk);
    // selected idle cycles must not stop the burst
    {ras_n, cas_n, we_n} = ENC_IDLE;
    idle(6);
    cs_n = 1'b1;
    `CHK(n_wr, 4)
    load_mode(1'b0, 2'h0, 3'h2, BLEN_8);
    n_rd = 0;
    issue(ENC_RD, 2'h0, 12'h000);
    issue(ENC_BTERM, 2'h0, 12'h000);
    idle(10);
    `CHK(n_rd, 2)
  endtask

  // burst type bit picks the order inside the block
  task automatic t_order();
    issue(ENC_MODE, 2'h0, 12'h02a);
    idle(MODE_DELAY);
    issue(ENC_RD, 2'h0, 12'h005);
    `CHK(core_col, 8'h05)
    idle(1);
    `CHK(core_col, 8'h04)
    idle(1);
    `CHK(core_col, 8'h07)
    idle(1);
    `CHK(core_col, 8'h06)
    load_mode(1'b0, 2'h0, 3'h2, BLEN_4);
    issue(ENC_RD, 2'h0, 12'h005);
    `CHK(core_col, 8'h05)
    idle(1);
    `CHK(core_col, 8'h06)
    idle(1);
    `CHK(core_col, 8'h07)
    idle(1);
    `CHK(core_col, 8'h04)
  endtask

  task automatic t_pre_ref();
    issue(ENC_PRE, 2'h2, 12'h000);
    `CHK({core_pre, core_pre_banks}, 5'h14)
    issue(ENC_PRE, 2'h1, 12'h400);
    `CHK(core_pre_banks, ALL_BANKS)
    issue(ENC_REF, 2'h3, 12'hfff);
    `CHK({core_ref, core_act, self_refresh}, 3'h4)
    row = core_ref_row;
    issue(ENC_REF, 2'h0, 12'h000);
    `CHK(core_ref_row !== row, 1'b1)
    cke = 1'b0;
    issue(ENC_REF, 2'h0, 12'h000);
    `CHK({core_ref, self_refresh}, 2'h3)
    issue(ENC_ACT, 2'h1, 12'h001);
    `CHK(core_act, 1'b0)
    cke = 1'b1;
    idle(2);
    `CHK(self_refresh, 1'b0)
  endtask

  initial
  begin
    {cke, cs_n, ras_n, cas_n, we_n} = 5'h1f;
    {bank_select_high, bank_select_low} = 2'h0;
    addr = 12'h000;
    dqm = 4'h0;
    dq_in = 32'h0f0f0f0f;
    rst_n = 1'b0;
    idle(16);
    rst_n = 1'b1;
    t_mode();
    t_act();
    t_latency();
    t_write();
    t_burst();
    t_order();
    t_pre_ref();
    print_verdict();
  end
endmodule // sdram_cmd_core_tb
